// [rtl/ttdp_params.svh]
// Constants for the transport-triggered datapath: field positions and reset values.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef TTDP_PARAMS_SVH
`define TTDP_PARAMS_SVH
`define TTDP_SLOT_W        16
`define TTDP_SRC_LSB       0
`define TTDP_SRC_W         8
`define TTDP_DST_LSB       8
`define TTDP_DST_W         7
`define TTDP_SIMM_FLAG_BIT 7
`define TTDP_SIMM_W        7
`define TTDP_VALID_BIT     15
`define TTDP_DATA_RST      32'h0000_0000
`define TTDP_SHIFT_W       5
`define TTDP_MUL_LAT       3
`endif

// [rtl/ttdp_pkg.sv]
// Types shared by the transport-triggered datapath.
// Assumes the constants header sits in the include path.
`include "ttdp_params.svh"
package ttdp_pkg;
  // Destination port codes; *_trig ports start the block's operation.
  typedef enum logic [6:0] {
    TTDP_DST_NONE     = 7'h00,
    TTDP_DST_ALU_OPND = 7'h01,
    TTDP_DST_ALU_ADD  = 7'h02,
    TTDP_DST_ALU_SUB  = 7'h03,
    TTDP_DST_ALU_NOT  = 7'h04,
    TTDP_DST_SHF_AMT  = 7'h05,
    TTDP_DST_SHF_SHL  = 7'h06,
    TTDP_DST_SHF_SHR  = 7'h07,
    TTDP_DST_MUL_OPND = 7'h08,
    TTDP_DST_MUL_TRIG = 7'h09,
    TTDP_DST_CUS_A    = 7'h0a,
    TTDP_DST_CUS_B    = 7'h0b,
    TTDP_DST_CUS_TRIG = 7'h0c,
    TTDP_DST_BANKA    = 7'h10,
    TTDP_DST_BANKB    = 7'h20
  } ttdp_dst_t;
  // Source port codes (bit 7 clear); bit 7 set marks a short constant.
  typedef enum logic [7:0] {
    TTDP_SRC_ZERO    = 8'h00,
    TTDP_SRC_ALU_OUT = 8'h01,
    TTDP_SRC_SHF_OUT = 8'h02,
    TTDP_SRC_MUL_OUT = 8'h03,
    TTDP_SRC_CUS_SUM = 8'h04,
    TTDP_SRC_CUS_XOR = 8'h05,
    TTDP_SRC_IMM     = 8'h08,
    TTDP_SRC_BANKA   = 8'h10,
    TTDP_SRC_BANKB   = 8'h20
  } ttdp_src_t;
  typedef enum logic [1:0] {
    TTDP_TPL_MOVES,
    TTDP_TPL_LIMM_HI,
    TTDP_TPL_LIMM_ALL
  } ttdp_tpl_t;
endpackage

// [rtl/ttdp_datapath.sv]
// Transport-triggered datapath: decodes one long instruction word a cycle into
// per-bus moves among execution blocks, two register banks and an immediate unit.
// Assumes the instruction supply presents a word with instr_valid on the same clock.
`timescale 1ns/1ps
`include "ttdp_params.svh"

// Contract
// - Instruction word commands transfers; operations run only as transfer side effects.
// - Writing a trigger port starts that execution block's operation.
// - One move slot per bus; each slot drives only its own bus.
// - Execution block input and output ports are holding registers; trigger ports here are not, their bus value feeds the operation directly.
// - A result port can move directly into another block's input port.
// - Short constants in a slot's source field are driven onto its bus.
// - Template picks long-constant slots and names the receiving immediate register.
// - Slots carrying long-constant pieces perform no transport that instruction.
// - Immediate unit is written only by the decoder, read-only toward buses.
// - Each operand has a fixed port; single-input operations use the trigger port.
// - Operand-to-port mapping is architectural and fixed in this block.
// - Input ports may be narrower than data, like the shift amount.
// - Execution blocks may have any number of input and output ports.
// - Blocks keep their own pipeline depths; no uniform pipeline length.
// - General registers are split over several small register banks.
// - Every bus reaches every socket and port in this full configuration.
module ttdp_datapath
  import ttdp_pkg::*;
#(
  parameter int DATA_W  = 32,
  parameter int BUSES   = 3,
  parameter int BANK_N  = 8,
  parameter int IMM_N   = 2,
  parameter int MUL_LAT = `TTDP_MUL_LAT
) (
  // Clock and reset.
  input  wire logic                           clock,
  input  wire logic                           arst_n,
  // Instruction supply.
  input  wire logic                           instr_valid,
  input  wire logic [1:0]                     instr_template,
  input  wire logic [$clog2(IMM_N)-1:0]       instr_imm_dst,
  input  wire logic [BUSES*`TTDP_SLOT_W-1:0]  instr_slots,
  // Observed state.
  output logic      [DATA_W-1:0]              alu_result,
  output logic      [DATA_W-1:0]              mul_result,
  output logic                                mul_done,
  output logic      [DATA_W-1:0]              imm_value
);

  localparam int SW  = `TTDP_SLOT_W;
  localparam int BIW = $clog2(BANK_N);
  localparam int IIW = $clog2(IMM_N);

  // Port registers of the execution blocks.
  logic [DATA_W-1:0] alu_opnd_reg, alu_opnd_next, alu_out_reg, alu_out_next;
  logic [`TTDP_SHIFT_W-1:0] shf_amt_reg, shf_amt_next;
  logic [DATA_W-1:0] shf_out_reg, shf_out_next;
  logic [DATA_W-1:0] mul_opnd_reg, mul_opnd_next, mul_out_reg, mul_out_next;
  logic [DATA_W-1:0] cus_a_reg, cus_a_next, cus_b_reg, cus_b_next;
  logic [DATA_W-1:0] cus_sum_reg, cus_sum_next, cus_xor_reg, cus_xor_next;
  logic [DATA_W-1:0] mul_pipe_reg [MUL_LAT], mul_pipe_next [MUL_LAT];
  logic [MUL_LAT-1:0] mul_vld_reg, mul_vld_next;
  logic              mul_done_reg, mul_done_next;
  // Split register banks and the immediate unit.
  logic [DATA_W-1:0] bank_a_reg [BANK_N], bank_a_next [BANK_N];
  logic [DATA_W-1:0] bank_b_reg [BANK_N], bank_b_next [BANK_N];
  logic [DATA_W-1:0] imm_reg [IMM_N], imm_next [IMM_N];
  logic [DATA_W-1:0] bus_val [BUSES];
  logic [BUSES-1:0]  bus_live;
  logic [DATA_W-1:0] limm_value;
  logic              limm_write;

  // Long-constant assembly: pieces come from full slots, low bits in the lowest slot used.
  always_comb begin
    limm_value = '0;
    limm_write = 1'b0;
    // Moves happen only when a word is present; no other issue path exists.
    for (int b = 0; b < BUSES; b++) begin
      bus_live[b] = instr_valid;
    end
    case (ttdp_tpl_t'(instr_template))
      TTDP_TPL_MOVES: begin
      end
      TTDP_TPL_LIMM_HI: begin
        // The last two slots carry the constant; other slots still move.
        limm_write = instr_valid;
        limm_value = DATA_W'({instr_slots[(BUSES-1)*SW +: SW], instr_slots[(BUSES-2)*SW +: SW]});
        bus_live[BUSES-1] = 1'b0;
        bus_live[BUSES-2] = 1'b0;
      end
      TTDP_TPL_LIMM_ALL: begin
        limm_write = instr_valid;
        limm_value = DATA_W'(instr_slots);
        bus_live   = '0;
      end
      default: begin
        bus_live = '0;
      end
    endcase
  end

  // Source side of every bus; all sources reach all buses.
  always_comb begin
    for (int b = 0; b < BUSES; b++) begin
      logic [SW-1:0] slot;
      logic [7:0]    src;
      slot = instr_slots[b*SW +: SW];
      src  = slot[`TTDP_SRC_LSB +: `TTDP_SRC_W];
      bus_val[b] = '0;
      if (src[`TTDP_SIMM_FLAG_BIT]) begin
        // Short constant, sign-extended onto the bus.
        bus_val[b] = DATA_W'($signed(src[`TTDP_SIMM_W-1:0]));
      end else if (src[5:4] == 2'b01) begin
        bus_val[b] = bank_a_reg[src[BIW-1:0]];
      end else if (src[5:4] == 2'b10) begin
        bus_val[b] = bank_b_reg[src[BIW-1:0]];
      end else if (src[3]) begin
        bus_val[b] = imm_reg[src[IIW-1:0]];
      end else begin
        case (ttdp_src_t'(src))
          TTDP_SRC_ALU_OUT: bus_val[b] = alu_out_reg;
          TTDP_SRC_SHF_OUT: bus_val[b] = shf_out_reg;
          TTDP_SRC_MUL_OUT: bus_val[b] = mul_out_reg;
          TTDP_SRC_CUS_SUM: bus_val[b] = cus_sum_reg;
          TTDP_SRC_CUS_XOR: bus_val[b] = cus_xor_reg;
          default:          bus_val[b] = '0;
        endcase
      end
    end
  end

  // Destination side: all moves land in the same cycle; later buses win a clash.
  always_comb begin
    alu_opnd_next = alu_opnd_reg;
    alu_out_next  = alu_out_reg;
    shf_amt_next  = shf_amt_reg;
    shf_out_next  = shf_out_reg;
    mul_opnd_next = mul_opnd_reg;
    cus_a_next    = cus_a_reg;
    cus_b_next    = cus_b_reg;
    cus_sum_next  = cus_sum_reg;
    cus_xor_next  = cus_xor_reg;
    mul_vld_next  = {mul_vld_reg[MUL_LAT-2:0], 1'b0};
    mul_pipe_next[0] = mul_pipe_reg[0];
    for (int s = 1; s < MUL_LAT; s++) begin
      mul_pipe_next[s] = mul_pipe_reg[s-1];
    end
    mul_out_next  = mul_vld_reg[MUL_LAT-1] ? mul_pipe_reg[MUL_LAT-1] : mul_out_reg;
    mul_done_next = mul_vld_reg[MUL_LAT-1];
    for (int r = 0; r < BANK_N; r++) begin
      bank_a_next[r] = bank_a_reg[r];
      bank_b_next[r] = bank_b_reg[r];
    end
    for (int b = 0; b < BUSES; b++) begin
      logic [6:0] dst;
      dst = instr_slots[b*SW + `TTDP_DST_LSB +: `TTDP_DST_W];
      if (bus_live[b]) begin
        if (dst[5:4] == 2'b01) begin
          bank_a_next[dst[BIW-1:0]] = bus_val[b];
        end else if (dst[5:4] == 2'b10) begin
          bank_b_next[dst[BIW-1:0]] = bus_val[b];
        end else begin
          // Operand bindings are fixed: last operand on the trigger port, except shifts, whose trigger takes the shifted value.
          case (ttdp_dst_t'(dst))
            TTDP_DST_ALU_OPND: alu_opnd_next = bus_val[b];
            TTDP_DST_ALU_ADD:  alu_out_next  = alu_opnd_reg + bus_val[b];
            TTDP_DST_ALU_SUB:  alu_out_next  = alu_opnd_reg - bus_val[b];
            TTDP_DST_ALU_NOT:  alu_out_next  = ~bus_val[b];
            TTDP_DST_SHF_AMT:  shf_amt_next  = bus_val[b][`TTDP_SHIFT_W-1:0];
            TTDP_DST_SHF_SHL:  shf_out_next  = bus_val[b] << shf_amt_reg;
            TTDP_DST_SHF_SHR:  shf_out_next  = bus_val[b] >> shf_amt_reg;
            TTDP_DST_MUL_OPND: mul_opnd_next = bus_val[b];
            TTDP_DST_MUL_TRIG: begin
              mul_pipe_next[0] = DATA_W'(mul_opnd_reg * bus_val[b]);
              mul_vld_next[0]  = 1'b1;
            end
            TTDP_DST_CUS_A:    cus_a_next = bus_val[b];
            TTDP_DST_CUS_B:    cus_b_next = bus_val[b];
            TTDP_DST_CUS_TRIG: begin
              // Three inputs, two results.
              cus_sum_next = cus_a_reg + cus_b_reg + bus_val[b];
              cus_xor_next = cus_a_reg ^ cus_b_reg ^ bus_val[b];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Immediate unit: written by the decoder only, never from a bus.
  always_comb begin
    for (int i = 0; i < IMM_N; i++) begin
      imm_next[i] = imm_reg[i];
    end
    if (limm_write) begin
      imm_next[instr_imm_dst] = limm_value;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alu_opnd_reg <= `TTDP_DATA_RST;
      alu_out_reg  <= `TTDP_DATA_RST;
      shf_amt_reg  <= '0;
      shf_out_reg  <= `TTDP_DATA_RST;
      mul_opnd_reg <= `TTDP_DATA_RST;
      mul_out_reg  <= `TTDP_DATA_RST;
      cus_a_reg    <= `TTDP_DATA_RST;
      cus_b_reg    <= `TTDP_DATA_RST;
      cus_sum_reg  <= `TTDP_DATA_RST;
      cus_xor_reg  <= `TTDP_DATA_RST;
      mul_vld_reg  <= '0;
      mul_done_reg <= 1'b0;
      for (int s = 0; s < MUL_LAT; s++) begin
        mul_pipe_reg[s] <= `TTDP_DATA_RST;
      end
      for (int r = 0; r < BANK_N; r++) begin
        bank_a_reg[r] <= `TTDP_DATA_RST;
        bank_b_reg[r] <= `TTDP_DATA_RST;
      end
      for (int i = 0; i < IMM_N; i++) begin
        imm_reg[i] <= `TTDP_DATA_RST;
      end
    end else begin
      alu_opnd_reg <= alu_opnd_next;
      alu_out_reg  <= alu_out_next;
      shf_amt_reg  <= shf_amt_next;
      shf_out_reg  <= shf_out_next;
      mul_opnd_reg <= mul_opnd_next;
      mul_out_reg  <= mul_out_next;
      cus_a_reg    <= cus_a_next;
      cus_b_reg    <= cus_b_next;
      cus_sum_reg  <= cus_sum_next;
      cus_xor_reg  <= cus_xor_next;
      mul_vld_reg  <= mul_vld_next;
      mul_done_reg <= mul_done_next;
      mul_pipe_reg <= mul_pipe_next;
      bank_a_reg   <= bank_a_next;
      bank_b_reg   <= bank_b_next;
      imm_reg      <= imm_next;
    end
  end

  assign alu_result = alu_out_reg;
  assign mul_result = mul_out_reg;
  assign mul_done   = mul_done_reg;
  assign imm_value  = imm_reg[0];

endmodule

// [bench/ttdp_datapath_chk.sv]
// Port checker for the transport-triggered datapath.
// Assumes it is bound into ttdp_datapath and inherits its parameters.
`timescale 1ns/1ps
module ttdp_datapath_chk #(
  parameter int DATA_W  = 32,
  parameter int BUSES   = 3,
  parameter int IMM_N   = 2,
  parameter int MUL_LAT = 3
) (
  // Clock and reset.
  input wire logic                     clock,
  input wire logic                     arst_n,
  // Instruction supply.
  input wire logic                     instr_valid,
  input wire logic [1:0]               instr_template,
  input wire logic [$clog2(IMM_N)-1:0] instr_imm_dst,
  input wire logic [BUSES*16-1:0]      instr_slots,
  // Observed state.
  input wire logic [DATA_W-1:0]        alu_result,
  input wire logic [DATA_W-1:0]        mul_result,
  input wire logic                     mul_done,
  input wire logic [DATA_W-1:0]        imm_value
);
  localparam int MUL_DLY = MUL_LAT + 1;
  logic        alu_trig;
  logic        mul_trig;
  logic        hi_alu;
  logic        not0;
  logic        imm0_wr;
  logic [31:0] not_exp;
  logic [31:0] imm_exp;
  // Long-constant slots are left out, since they must not move anything.
  always_comb begin
    alu_trig = 1'b0;
    mul_trig = 1'b0;
    hi_alu   = 1'b0;
    for (int b = 0; b < BUSES; b++) begin
      if (instr_valid && (instr_template == 2'h0 || (instr_template == 2'h1 && b < BUSES - 2))) begin
        alu_trig |= instr_slots[b*16+8+:7] inside {7'h02, 7'h03, 7'h04};
        mul_trig |= instr_slots[b*16+8+:7] == 7'h09;
        hi_alu   |= b > 0 && instr_slots[b*16+8+:7] inside {7'h02, 7'h03, 7'h04};
      end
    end
  end
  assign not0    = instr_valid && instr_template == 2'h0 && instr_slots[14:7] == 8'h09 && !hi_alu;
  assign not_exp = ~{{25{instr_slots[6]}}, instr_slots[6:0]};
  assign imm0_wr = instr_valid && instr_template inside {2'h1, 2'h2} && instr_imm_dst == '0;
  assign imm_exp = instr_template == 2'h1 ? instr_slots[BUSES*16-1-:32] : instr_slots[31:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_alu_cause; !$stable(alu_result) |-> $past(alu_trig); endproperty
  a_alu_cause: assert property (p_alu_cause) else $error("alu result moved without a trigger");
  property p_not_trig; not0 |=> alu_result == $past(not_exp); endproperty
  a_not_trig: assert property (p_not_trig) else $error("single-input negation wrong");
  property p_mul_lat; mul_trig |-> ##MUL_DLY mul_done; endproperty
  a_mul_lat: assert property (p_mul_lat) else $error("multiply done late");
  property p_mul_cause; mul_done |-> $past(mul_trig, MUL_DLY); endproperty
  a_mul_cause: assert property (p_mul_cause) else $error("multiply done without trigger");
  property p_limm; imm0_wr |=> imm_value == $past(imm_exp); endproperty
  a_limm: assert property (p_limm) else $error("long constant assembled wrong");
  property p_imm_cause; !$stable(imm_value) |-> $past(imm0_wr); endproperty
  a_imm_cause: assert property (p_imm_cause) else $error("immediate written by a move");
  property p_limm_nomove; instr_valid && instr_template == 2'h2 |=> $stable(alu_result); endproperty
  a_limm_nomove: assert property (p_limm_nomove) else $error("constant slot moved data");
  property p_idle; !instr_valid |=> $stable(alu_result) && $stable(imm_value); endproperty
  a_idle: assert property (p_idle) else $error("state changed with no word");
endmodule

bind ttdp_datapath ttdp_datapath_chk #(.DATA_W(DATA_W), .BUSES(BUSES), .IMM_N(IMM_N),
  .MUL_LAT(MUL_LAT)) i_ttdp_datapath_chk (.clock, .arst_n, .instr_valid, .instr_template,
  .instr_imm_dst, .instr_slots, .alu_result, .mul_result, .mul_done, .imm_value);

// [bench/ttdp_imem.sv]
// Instruction supply model: presents one queued word per cycle.
// Assumes the bench pushes words; between words the slot lines toggle.
`timescale 1ns/1ps
module ttdp_imem (
  // Clock.
  input wire logic clock,
  // Instruction word.
  output logic        instr_valid,
  output logic [1:0]  instr_template,
  output logic        instr_imm_dst,
  output logic [47:0] instr_slots
);
  logic [50:0] q[$];
  task automatic push(input logic [50:0] wd);
    q.push_back(wd);
  endtask
  initial begin
    instr_valid = 1'b0;
    {instr_template, instr_imm_dst, instr_slots} = 51'h0;
    forever begin
      @(posedge clock);
      #1;
      instr_valid = q.size() != 0;
      if (instr_valid) begin
        {instr_template, instr_imm_dst, instr_slots} = q.pop_front();
      end else begin
        instr_slots = ~instr_slots;
      end
    end
  end
endmodule

// [bench/ttdp_datapath_test.sv]
// Self-checking bench for the transport-triggered datapath.
// Assumes the supply model and the bound port checker.
`timescale 1ns/1ps
module ttdp_datapath_test;
  logic        clock;
  logic        arst_n;
  logic        instr_valid;
  logic [1:0]  instr_template;
  logic        instr_imm_dst;
  logic [47:0] instr_slots;
  logic [31:0] alu_result;
  logic [31:0] mul_result;
  logic        mul_done;
  logic [31:0] imm_value;
  logic [15:0] rnd;
  logic [6:0]  a;
  logic [6:0]  b;
  logic [31:0] e;
  int          op;
  int          t;
  int          k;
  int          miscompares;
  int          checks_done;
  ttdp_imem i_ttdp_imem (.clock(clock), .instr_valid(instr_valid),
    .instr_template(instr_template), .instr_imm_dst(instr_imm_dst), .instr_slots(instr_slots));
  ttdp_datapath i_ttdp_datapath (.clock(clock), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_template(instr_template), .instr_imm_dst(instr_imm_dst), .instr_slots(instr_slots),
    .alu_result(alu_result), .mul_result(mul_result), .mul_done(mul_done),
    .imm_value(imm_value));
  function automatic logic [47:0] at(input logic [7:0] src, input logic [6:0] dst, input int bus);
    return {32'h0, 1'b0, dst, src} << (16 * bus);
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] alu_exp(input int op, input logic [6:0] x, input logic [6:0] y);
    return op == 0 ? {{25{x[6]}}, x} + {{25{y[6]}}, y} :
           op == 1 ? {{25{x[6]}}, x} - {{25{y[6]}}, y} : ~{{25{y[6]}}, y};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic go(input logic [1:0] tpl, input logic dst, input logic [47:0] slots);
    i_ttdp_imem.push({tpl, dst, slots});
  endtask
  // Waits until the last word is on the bus, then lets n edges land.
  task automatic drain(input int n);
    k = 0;
    while (i_ttdp_imem.q.size() != 0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    if (k == 100) miscompares++;
    if (k == 100) complete_run();
    repeat (n) @(negedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    arst_n = 1'b0;
    rnd = 16'h0020;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    #1 arst_n = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      a = i == 0 ? 7'h40 : rnd[6:0];
      b = i == 0 ? 7'h3f : rnd[13:7];
      op = i % 3;
      t = rnd[15:14] % 3;
      e = alu_exp(op, a, b);
      go(2'h0, 1'b0, at({1'b1, a}, 7'h01, t));
      // The operand rewritten beside the trigger must not reach this result.
      go(2'h0, 1'b0, at({1'b1, b}, 7'h02 + 7'(op), t) | at({1'b1, ~a}, 7'h01, (t + 1) % 3));
      drain(1);
      cmp(alu_result, e);
    end
    go(2'h0, 1'b0, at(8'h86, 7'h13, 0));
    // The operand must land a cycle before the trigger that uses it.
    go(2'h0, 1'b0, at(8'h13, 7'h08, 1));
    go(2'h0, 1'b0, at(8'h01, 7'h09, 2));
    drain(0);
    k = 0;
    while (mul_done !== 1'b1 && k < 10) begin
      @(negedge clock);
      k++;
    end
    if (k == 10) miscompares++;
    cmp(mul_result, 32'h6 * e);
    go(2'h1, 1'b0, {16'h0283, 16'h0285, 1'b0, 7'h04, 8'h87});
    drain(1);
    cmp(imm_value, 32'h0283_0285);
    cmp(alu_result, ~32'h7);
    go(2'h2, 1'b1, 48'h0000_1234_5678);
    go(2'h0, 1'b0, at(8'h09, 7'h04, 2));
    drain(1);
    cmp(alu_result, ~32'h1234_5678);
    cmp(imm_value, 32'h0283_0285);
    go(2'h0, 1'b0, at(8'ha3, 7'h05, 0));
    go(2'h0, 1'b0, at(8'h81, 7'h06, 1));
    go(2'h0, 1'b0, at(8'h02, 7'h04, 2));
    drain(1);
    cmp(alu_result, ~32'h8);
    go(2'h0, 1'b0, at(8'h81, 7'h0a, 0) | at(8'h82, 7'h0b, 1) | at(8'h83, 7'h20, 2));
    go(2'h0, 1'b0, at(8'h20, 7'h0c, 0));
    go(2'h0, 1'b0, at(8'h04, 7'h04, 1));
    drain(1);
    cmp(alu_result, ~32'h6);
    go(2'h0, 1'b0, at(8'h05, 7'h04, 0));
    drain(1);
    cmp(alu_result, ~32'h0);
    complete_run();
  end
endmodule
